// ---- pin_env.sv ----
`timescale 1ns/1ns
`default_nettype none

module pin_env (
	// Pad side of the port
	input wire logic [7:0] padOut,
	input wire logic [7:0] padOe,
	// Levels the board puts on released pins
	input wire logic [7:0] boardLevel,
	// Level seen on each pad
	output logic [7:0] padLevel
);
	// A driven pad shows its latch, a released one the board level
	assign padLevel = (padOe & padOut) | (~padOe & boardLevel);
endmodule : pin_env

`default_nettype wire

// ---- port_bit_rmw.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_pin_defines.svh"

module port_bit_rmw (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Request
	input wire logic start,
	input wire port_pin_pkg::bitOp_t op,
	// Byte read back from the addressed register
	input wire logic [7:0] readByte,
	// Status and write side
	output logic busy,
	output logic [7:0] rmwAddr,
	output logic wrEn,
	output logic [7:0] wrByte
);

	port_pin_pkg::rmwState_t state_r, state_nxt;
	port_pin_pkg::bitOp_t op_r, op_nxt;
	logic [7:0] byte_r, byte_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		byte_nxt = byte_r;
		unique case (state_r)
			port_pin_pkg::RMW_IDLE: begin
				if (start) begin
					op_nxt = op;
					state_nxt = port_pin_pkg::RMW_READ;
				end
			end
			port_pin_pkg::RMW_READ: begin
				// Whole byte taken as a read would see it
				byte_nxt = readByte;
				state_nxt = port_pin_pkg::RMW_MODIFY;
			end
			port_pin_pkg::RMW_MODIFY: begin
				byte_nxt[op_r.idx] = op_r.setBit;
				state_nxt = port_pin_pkg::RMW_WRITE;
			end
			port_pin_pkg::RMW_WRITE: begin
				state_nxt = port_pin_pkg::RMW_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= port_pin_pkg::RMW_IDLE;
			op_r <= '0;
			byte_r <= `PORT_DATA_RST;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			byte_r <= byte_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign busy = (state_r != port_pin_pkg::RMW_IDLE);
	assign rmwAddr = op_r.addr;
	// Full byte goes back, other bits as they were read
	assign wrEn = (state_r == port_pin_pkg::RMW_WRITE);
	assign wrByte = byte_r;

endmodule : port_bit_rmw
`default_nettype wire

// ---- port_pin_data_direction_access.sv ----
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "port_pin_defines.svh"

module port_pin_data_direction_access (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire port_pin_pkg::regAccess_t regAcc,
	output logic [7:0] rdData,
	// Bit set and bit clear requests
	input wire logic bitOpStb,
	input wire port_pin_pkg::bitOp_t bitOp,
	output logic bitOpBusy,
	// Port pins
	input wire logic [7:0] portPinsIn,
	output logic [7:0] portPinsOut,
	output logic [7:0] portPinsOe
);

	logic [7:0] latch_r, latch_nxt;
	logic [7:0] dir_r, dir_nxt;
	logic [7:0] rdData_r, rdData_nxt;
	logic [7:0] rmwAddr;
	logic [7:0] rmwReadByte;
	logic [7:0] rmwWrByte;
	logic rmwWrEn;
	logic rmwStart;

	////////////////////////////////////////////////////////////////////////
	// Byte seen by any read at addr; shared by bus and bit ops
	function automatic logic [7:0] readBack(
		input logic [7:0] addr,
		input logic [7:0] dir,
		input logic [7:0] latch,
		input logic [7:0] pins
	);
		logic [7:0] val;
		val = `PORT_UNMAPPED_READ;
		if (addr == `PORT_ADDR_DATA) begin
			// Per bit mix of latch and pin level
			val = (dir & latch) | (~dir & pins);
		end else if (addr == `PORT_ADDR_DIR) begin
			// Held value never visible
			val = `PORT_DIR_READ;
		end
		return val;
	endfunction : readBack

	////////////////////////////////////////////////////////////////////////
	// Bit op sequencer; new requests ignored while one runs
	assign rmwStart = bitOpStb && !bitOpBusy;
	assign rmwReadByte = readBack(rmwAddr, dir_r, latch_r, portPinsIn);

	port_bit_rmw u_rmw (
		.mclk(mclk),
		.reset(reset),
		.start(rmwStart),
		.op(bitOp),
		.readByte(rmwReadByte),
		.busy(bitOpBusy),
		.rmwAddr(rmwAddr),
		.wrEn(rmwWrEn),
		.wrByte(rmwWrByte)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers; a bit op write beats a bus write to the same register
	always_comb begin
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		rdData_nxt = rdData_r;
		if (regAcc.wrStb && regAcc.addr == `PORT_ADDR_DATA) begin
			latch_nxt = regAcc.wrData;
		end
		if (regAcc.wrStb && regAcc.addr == `PORT_ADDR_DIR) begin
			dir_nxt = regAcc.wrData;
		end
		if (rmwWrEn && rmwAddr == `PORT_ADDR_DATA) begin
			// Input bits take whatever was read back
			latch_nxt = rmwWrByte;
		end
		if (rmwWrEn && rmwAddr == `PORT_ADDR_DIR) begin
			// Read gave all ones, so input pins may turn output
			dir_nxt = rmwWrByte;
		end
		if (regAcc.rdStb) begin
			rdData_nxt = readBack(regAcc.addr, dir_r, latch_r, portPinsIn);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			latch_r <= `PORT_DATA_RST;
			dir_r <= `PORT_DIR_RST;
			rdData_r <= `PORT_UNMAPPED_READ;
		end else begin
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rdData = rdData_r;
	assign portPinsOut = latch_r;
	assign portPinsOe = dir_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_DATA_READ: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.rdStb && regAcc.addr == `PORT_ADDR_DATA |=>
			rdData == (($past(dir_r) & $past(latch_r)) |
			(~$past(dir_r) & $past(portPinsIn))))
		else $error("Data read mixes pins and latch wrongly");

	AST_DIR_READ: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.rdStb && regAcc.addr == `PORT_ADDR_DIR |=>
			rdData == `PORT_DIR_READ)
		else $error("Direction read not all ones");

	AST_DIR_OE: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.wrStb && regAcc.addr == `PORT_ADDR_DIR &&
			!(rmwWrEn && rmwAddr == `PORT_ADDR_DIR) |=>
			portPinsOe == $past(regAcc.wrData))
		else $error("Output enable does not follow direction write");

	AST_PIN_DRIVE: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.wrStb && regAcc.addr == `PORT_ADDR_DATA &&
			!(rmwWrEn && rmwAddr == `PORT_ADDR_DATA) |=>
			((portPinsOut ^ $past(regAcc.wrData)) & portPinsOe) == 8'h00)
		else $error("Output pin not driving its latch bit");

	AST_BIT_SET: assert property (
		@(posedge mclk) disable iff (reset)
		rmwStart && bitOp.setBit |=> ##2
			rmwWrEn && rmwWrByte[$past(bitOp.idx, 3)] == 1'b1)
		else $error("Bit set did not write a one");

	AST_BIT_CLR: assert property (
		@(posedge mclk) disable iff (reset)
		rmwStart && !bitOp.setBit |=> ##2
			rmwWrEn && rmwWrByte[$past(bitOp.idx, 3)] == 1'b0)
		else $error("Bit clear did not write a zero");

	AST_FULL_WRITE: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.wrStb && regAcc.addr == `PORT_ADDR_DATA &&
			!(rmwWrEn && rmwAddr == `PORT_ADDR_DATA) |=>
			latch_r == $past(regAcc.wrData))
		else $error("Data write did not store all eight bits");

	AST_SHARED_ADDR: assert property (
		@(posedge mclk) disable iff (reset)
		regAcc.rdStb && regAcc.addr == `PORT_ADDR_DATA &&
			dir_r == 8'h00 |=> rdData == $past(portPinsIn))
		else $error("Pin levels not read at data address");

	AST_RMW_SEQ: assert property (
		@(posedge mclk) disable iff (reset)
		rmwStart |=> bitOpBusy && !rmwWrEn ##1 bitOpBusy && !rmwWrEn
			##1 bitOpBusy && rmwWrEn ##1 !bitOpBusy)
		else $error("Bit op not read, modify, write in three cycles");

	AST_RMW_READBACK: assert property (
		@(posedge mclk) disable iff (reset)
		rmwStart && bitOp.addr == `PORT_ADDR_DIR |=> ##2
			(rmwWrByte | (8'h01 << $past(bitOp.idx, 3))) == 8'hFF)
		else $error("Direction bit op did not start from all ones");

	// Only the targeted bit may differ from what was read
	AST_RMW_KEEP: assert property (
		@(posedge mclk) disable iff (reset)
		rmwStart |=> ##2
			((rmwWrByte ^ $past(rmwReadByte, 2)) &
			~(8'h01 << $past(bitOp.idx, 3))) == 8'h00)
		else $error("Bit op changed a bit it did not target");

	AST_RMW_DATA_LANDS: assert property (
		@(posedge mclk) disable iff (reset)
		rmwWrEn && rmwAddr == `PORT_ADDR_DATA |=>
			portPinsOut == $past(rmwWrByte))
		else $error("Bit op byte not stored in the latch");

	AST_RMW_DIR_LANDS: assert property (
		@(posedge mclk) disable iff (reset)
		rmwWrEn && rmwAddr == `PORT_ADDR_DIR |=>
			portPinsOe == $past(rmwWrByte))
		else $error("Bit op byte not stored as direction");

	AST_RDDATA_HOLD: assert property (
		@(posedge mclk) disable iff (reset)
		!regAcc.rdStb |=> $stable(rdData))
		else $error("Read data changed without a read");

	AST_DIR_HOLD: assert property (
		@(posedge mclk) disable iff (reset)
		!(regAcc.wrStb && regAcc.addr == `PORT_ADDR_DIR) &&
			!(rmwWrEn && rmwAddr == `PORT_ADDR_DIR) |=>
			$stable(portPinsOe))
		else $error("Direction changed without a write");

	AST_LATCH_HOLD: assert property (
		@(posedge mclk) disable iff (reset)
		!(regAcc.wrStb && regAcc.addr == `PORT_ADDR_DATA) &&
			!(rmwWrEn && rmwAddr == `PORT_ADDR_DATA) |=>
			$stable(portPinsOut))
		else $error("Latch changed without a write");

	// Reset must leave every pin released and no bit op pending
	AST_RESET_STATE: assert property (
		@(posedge mclk)
		reset |=> portPinsOe == `PORT_DIR_RST &&
			portPinsOut == `PORT_DATA_RST && !bitOpBusy)
		else $error("Pins not released after reset");

endmodule : port_pin_data_direction_access
`default_nettype wire

// ---- port_pin_defines.svh ----
`ifndef PORT_PIN_DEFINES_SVH
`define PORT_PIN_DEFINES_SVH

// Register offsets on the byte register port
`define PORT_ADDR_DATA 8'h00
`define PORT_ADDR_DIR 8'h01

// Field positions and widths
`define PORT_WIDTH 8
`define PORT_MSB 7
`define PORT_IDX_MSB 2

// Reset values: all pins inputs, latch cleared
`define PORT_DATA_RST 8'h00
`define PORT_DIR_RST 8'h00

// Fixed read values
`define PORT_DIR_READ 8'hFF
`define PORT_UNMAPPED_READ 8'h00

`endif

// ---- port_pin_pkg.sv ----
`default_nettype none

package port_pin_pkg;

	// One bit set or bit clear request from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] idx;
		logic setBit;
	} bitOp_t;

	// One byte access on the register port
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrStb;
		logic rdStb;
	} regAccess_t;

	typedef enum logic [1:0] {
		RMW_IDLE,
		RMW_READ,
		RMW_MODIFY,
		RMW_WRITE
	} rmwState_t;

endpackage : port_pin_pkg

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic mclk;
	logic reset;
	port_pin_pkg::regAccess_t regAcc;
	port_pin_pkg::bitOp_t bitOp;
	logic bitOpStb;
	logic bitOpBusy;
	logic [7:0] rdData;
	logic [7:0] portPinsIn;
	logic [7:0] portPinsOut;
	logic [7:0] portPinsOe;
	logic [7:0] boardLevel;
	int num_errors;
	int check_count;

	port_pin_data_direction_access u_port_pin_data_direction_access (
		.mclk(mclk), .reset(reset), .regAcc(regAcc), .rdData(rdData),
		.bitOpStb(bitOpStb), .bitOp(bitOp), .bitOpBusy(bitOpBusy),
		.portPinsIn(portPinsIn), .portPinsOut(portPinsOut),
		.portPinsOe(portPinsOe));

	pin_env u_pin_env (
		.padOut(portPinsOut), .padOe(portPinsOe),
		.boardLevel(boardLevel), .padLevel(portPinsIn));

	////////////////////////////////////////////////////////////////
	task close_out;
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAcc <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
		@(posedge mclk);
		regAcc.wrStb <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regAcc <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
		@(posedge mclk);
		regAcc.rdStb <= 1'b0;
		#1;
		chk(rdData, exp);
	endtask : rd

	// Busy must fall within a few cycles, else the run is cut short
	task bit_op(input logic [7:0] a, input logic [2:0] i, input logic s);
		int n;
		n = 0;
		@(posedge mclk);
		bitOpStb <= 1'b1;
		bitOp <= '{addr: a, idx: i, setBit: s};
		@(posedge mclk);
		bitOpStb <= 1'b0;
		#1;
		while (bitOpBusy === 1'b1 && n < 10) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(8'(n), 8'h03);
		if (n == 10)
			close_out();
	endtask : bit_op

	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		reset = 1'b1;
		regAcc = '0;
		bitOp = '0;
		bitOpStb = 1'b0;
		boardLevel = 8'h40;
		num_errors = 0;
		check_count = 0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		rd(8'h01, 8'hFF);
		rd(8'h00, 8'h40);
		rd(8'h05, 8'h00);
		wr(8'h00, 8'h80);
		wr(8'h01, 8'h3F);
		chk(portPinsOe, 8'h3F);
		chk(portPinsOut, 8'h80);
		wr(8'h05, 8'hAA);
		chk(portPinsOut, 8'h80);
		rd(8'h01, 8'hFF);
		rd(8'h00, 8'h40);
		// Input pins leak into the latch through the read-back
		bit_op(8'h00, 3'h0, 1'b1);
		chk(portPinsOut, 8'h41);
		rd(8'h00, 8'h41);
		// Direction reads as all ones, so inputs turn to outputs
		bit_op(8'h01, 3'h0, 1'b0);
		chk(portPinsOe, 8'hFE);
		@(posedge mclk);
		boardLevel <= 8'h01;
		rd(8'h00, 8'h41);
		// Shadow copies written whole restore the intended setup
		wr(8'h00, 8'h81);
		wr(8'h01, 8'h3E);
		chk(portPinsOut, 8'h81);
		chk(portPinsOe, 8'h3E);
		rd(8'h00, 8'h01);
		// Second reset in mid-run returns every pin to input
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		#1;
		chk(portPinsOe, 8'h00);
		chk(portPinsOut, 8'h00);
		rd(8'h00, 8'h01);
		close_out();
	end
endmodule : tb

`default_nettype wire
